// ===== gtm_consts.vh
// Behaviour
// R1 - Partner holds the capture pin two clocks after each edge; max quarter clock.
// R2 - Edge count, edge time and PWM run the plain counter without prescaler.
// R3 - Capture mode select clear: half counts selected edges as a down-counter.
// R4 - Software sets match so load minus match equals the wanted edge count.
// R5 - Each qualifying edge decrements; reaching match sets raw match flag.
// R6 - At match the counter reloads from interval load and the enable clears.
// R7 - Capture mode select set: free-running down-counter from load, 0xffff at reset.
// R8 - Edge time: selected edge copies counter to timer value, sets capture flag.
// R9 - Edge time counting continues until disabled; reloads from load at zero.
// R10 - Captured value holds until the next selected edge overwrites it.
// R11 - PWM when alternate select 1, capture select 0, mode field 2.
// R12 - PWM counter counts to zero, reloads next cycle, runs until disabled.
// R13 - PWM mode sets no status flag.
// R14 - PWM output asserts at start value, drops at match; invert bit flips it.
// R15 - Software disables the timer before changing configuration.
// R16 - 32-bit one-shot or periodic: configuration 0, mode 1 or 2, load, enable.
// R17 - Writing 1 to a clear bit clears the matching status flag.
// R18 - Clock mode: 32.768 kHz on even pin, configuration 1, match, enable.
// R19 - Clock mode match sets clock match flag; counting continues until disabled.
// R20 - 16-bit one-shot or periodic: configuration 4, mode 1 or 2, prescale, load.
// R21 - One-shot stops after timeout; periodic keeps counting.
// R22 - Software enables the timer clock gate before use.
// R23 - 16-bit timer at zero reloads load and prescale next cycle; one-shot disables.
// R24 - 32-bit modes join both halves into one down-counter.
// R25 - Capture pin is synchronised before edge detection.
`ifndef GTM_CONSTS_VH
`define GTM_CONSTS_VH

`define GTM_OFF_CFG   12'h000
`define GTM_OFF_AMR   12'h004
`define GTM_OFF_BMR   12'h008
`define GTM_OFF_CTL   12'h00c
`define GTM_OFF_IMR   12'h018
`define GTM_OFF_RIS   12'h01c
`define GTM_OFF_MIS   12'h020
`define GTM_OFF_ICR   12'h024
`define GTM_OFF_AILR  12'h028
`define GTM_OFF_BILR  12'h02c
`define GTM_OFF_AMAT  12'h030
`define GTM_OFF_BMAT  12'h034
`define GTM_OFF_APR   12'h038
`define GTM_OFF_BPR   12'h03c
`define GTM_OFF_AVAL  12'h048
`define GTM_OFF_BVAL  12'h04c

`define GTM_CFG_32    3'h0
`define GTM_CFG_RTC   3'h1

`define GTM_MR_ONE    2'h1
`define GTM_MR_PER    2'h2
`define GTM_MR_CAP    2'h3
`define GTM_MR_CMR    2
`define GTM_MR_AMS    3

`define GTM_HALF_SH   8
`define GTM_CTL_EN    0
`define GTM_CTL_EVT   2
`define GTM_CTL_STALL_OVERRIDE_CLOCK_BIT 4
`define GTM_CTL_PWML  6

`define GTM_ST_TO     0
`define GTM_ST_CM     1
`define GTM_ST_CE     2
`define GTM_ST_RTC    3

`define GTM_EVT_RISE  2'h0
`define GTM_EVT_FALL  2'h1

`define GTM_RST_CNT   16'hffff
`define GTM_RST_PR    8'h00
`define GTM_RTC_DIV   15'h7fff

`endif

// ===== gtm_edge_sync.v
`timescale 1ns/1ps
module gtm_edge_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire pin,
  output wire rise,
  output wire fall
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin; // see R25
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule

// ===== gtm_pin_model.sv
`timescale 1ns/1ps
module gtm_pin_model
(
  input  wire pclk,
  output reg  pin
);
  initial pin = 1'b0;
  // Each level is held five clocks, more than twice what the input stage needs
  task flip(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      pin <= ~pin;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

// ===== gtm_timer.v
`timescale 1ns/1ps
`include "gtm_consts.vh"
module gtm_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ccp_a_in,
  input  wire        ccp_b_in,
  output reg         pwm_a_out,
  output reg         pwm_b_out
);
  localparam [5:0] K_IDLE = 6'h01;
  localparam [5:0] K_ONE  = 6'h02;
  localparam [5:0] K_PER  = 6'h04;
  localparam [5:0] K_CNT  = 6'h08;
  localparam [5:0] K_TIM  = 6'h10;
  localparam [5:0] K_PWM  = 6'h20;

  reg  [2:0]  cfg;
  reg  [3:0]  tmr     [0:1];
  reg  [15:0] ctl;
  reg  [15:0] imr;
  reg  [15:0] ris;
  reg  [15:0] ilr     [0:1];
  reg  [15:0] mat     [0:1];
  reg  [7:0]  pr      [0:1];
  reg  [15:0] cnt     [0:1];
  reg  [7:0]  psc     [0:1];
  reg  [15:0] cap     [0:1];
  reg  [1:0]  lvl;
  reg  [14:0] rdiv;
  reg  [15:0] next_ctl;
  reg  [15:0] next_ris;
  reg  [15:0] next_cnt [0:1];
  reg  [7:0]  next_psc [0:1];
  reg  [15:0] next_cap [0:1];
  reg  [1:0]  next_lvl;
  reg  [14:0] next_rdiv;
  reg  [15:0] set_st;
  reg  [31:0] c32;
  reg  [5:0]  k;
  reg  [31:0] rdata;
  reg         hit;
  integer     h;
  integer     g;
  wire [1:0]  rise;
  wire [1:0]  fall;
  wire        acc = psel & penable;
  wire        wr = acc & pready & pwrite;

  // Mode of one 16-bit half from configuration and its mode register
  function [5:0] gtm_kind;
    input [2:0] c;
    input [3:0] m;
    begin
      if (!c[2])
        gtm_kind = K_IDLE;
      else if (m[`GTM_MR_AMS])
        gtm_kind = (m[1:0] == `GTM_MR_PER && !m[`GTM_MR_CMR]) ? K_PWM : K_IDLE; // see R11
      else if (m[1:0] == `GTM_MR_CAP)
        gtm_kind = m[`GTM_MR_CMR] ? K_TIM : K_CNT; // see R3 see R7
      else if (m[1:0] == `GTM_MR_ONE)
        gtm_kind = K_ONE;
      else if (m[1:0] == `GTM_MR_PER)
        gtm_kind = K_PER;
      else
        gtm_kind = K_IDLE;
    end
  endfunction

  // Edge qualifier from the event field
  function gtm_edge;
    input [1:0] ev;
    input       r;
    input       f;
    begin
      if (ev == `GTM_EVT_RISE)
        gtm_edge = r;
      else if (ev == `GTM_EVT_FALL)
        gtm_edge = f;
      else
        gtm_edge = r | f;
    end
  endfunction

  gtm_edge_sync u_sync_a
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ccp_a_in),
    .rise    (rise[0]),
    .fall    (fall[0])
  );

  gtm_edge_sync u_sync_b
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ccp_b_in),
    .rise    (rise[1]),
    .fall    (fall[1])
  );

  // Counter engine
  always @*
  begin
    next_ctl = ctl;
    next_lvl = lvl;
    next_rdiv = rdiv;
    set_st = 16'h0000;
    c32 = {cnt[1], cnt[0]};
    k = K_IDLE;
    for (h = 0; h < 2; h = h + 1)
    begin
      next_cnt[h] = cnt[h];
      next_psc[h] = psc[h];
      next_cap[h] = cap[h];
      k = gtm_kind(cfg, tmr[h]);
      if (ctl[h*`GTM_HALF_SH+`GTM_CTL_EN])
      begin
        case (k)
          K_ONE, K_PER:
          begin
            if (cnt[h] == 16'h0000)
            begin
              next_cnt[h] = ilr[h]; // see R23
              next_psc[h] = pr[h];
              set_st[h*`GTM_HALF_SH+`GTM_ST_TO] = 1'b1;
              if (k == K_ONE)
                next_ctl[h*`GTM_HALF_SH+`GTM_CTL_EN] = 1'b0; // see R21
            end
            else if (psc[h] == 8'h00)
            begin
              next_cnt[h] = cnt[h] - 16'h0001;
              next_psc[h] = pr[h];
            end
            else
              next_psc[h] = psc[h] - 8'h01;
          end
          K_CNT:
          begin
            if (gtm_edge(ctl[h*`GTM_HALF_SH+`GTM_CTL_EVT +: 2], rise[h], fall[h]))
            begin
              if (cnt[h] - 16'h0001 == mat[h]) // see R5
              begin
                set_st[h*`GTM_HALF_SH+`GTM_ST_CM] = 1'b1;
                next_cnt[h] = ilr[h]; // see R6
                next_ctl[h*`GTM_HALF_SH+`GTM_CTL_EN] = 1'b0;
              end
              else
                next_cnt[h] = cnt[h] - 16'h0001; // see R2
            end
          end
          K_TIM:
          begin
            next_cnt[h] = (cnt[h] == 16'h0000) ? ilr[h] : cnt[h] - 16'h0001; // see R9 see R2
            if (gtm_edge(ctl[h*`GTM_HALF_SH+`GTM_CTL_EVT +: 2], rise[h], fall[h]))
            begin
              next_cap[h] = cnt[h]; // see R8 see R10
              set_st[h*`GTM_HALF_SH+`GTM_ST_CE] = 1'b1;
            end
          end
          K_PWM:
          begin
            next_cnt[h] = (cnt[h] == 16'h0000) ? ilr[h] : cnt[h] - 16'h0001; // see R12 see R13
            if (cnt[h] == ilr[h])
              next_lvl[h] = 1'b1; // see R14
            else if (cnt[h] == mat[h])
              next_lvl[h] = 1'b0;
          end
          default:
          begin
            next_cnt[h] = cnt[h];
          end
        endcase
      end
    end
    if (cfg == `GTM_CFG_32 && ctl[`GTM_CTL_EN] && (tmr[0][1:0] == `GTM_MR_ONE || tmr[0][1:0] == `GTM_MR_PER))
    begin
      if (c32 == 32'h00000000)
      begin
        {next_cnt[1], next_cnt[0]} = {ilr[1], ilr[0]}; // see R24
        set_st[`GTM_ST_TO] = 1'b1;
        if (tmr[0][1:0] == `GTM_MR_ONE)
          next_ctl[`GTM_CTL_EN] = 1'b0; // see R21
      end
      else
        {next_cnt[1], next_cnt[0]} = c32 - 32'h00000001;
    end
    if (cfg == `GTM_CFG_RTC && ctl[`GTM_CTL_EN] && rise[0])
    begin
      next_rdiv = rdiv + 15'h0001;
      if (rdiv == `GTM_RTC_DIV)
      begin
        if (c32 == {mat[1], mat[0]})
        begin
          {next_cnt[1], next_cnt[0]} = 32'h00000000; // see R19
          set_st[`GTM_ST_RTC] = 1'b1;
        end
        else
          {next_cnt[1], next_cnt[0]} = c32 + 32'h00000001;
      end
    end
    next_ris = (ris & ~((wr && paddr == `GTM_OFF_ICR) ? pwdata[15:0] : 16'h0000)) | set_st; // see R17
    if (wr && paddr == `GTM_OFF_CTL)
      next_ctl = pwdata[15:0];
    if (wr && paddr == `GTM_OFF_CFG && pwdata[2:0] == `GTM_CFG_RTC)
      {next_cnt[1], next_cnt[0]} = 32'h00000001;
    if (wr && paddr == `GTM_OFF_AILR)
    begin
      next_cnt[0] = pwdata[15:0];
      if (!cfg[2])
        next_cnt[1] = pwdata[31:16];
    end
    if (wr && paddr == `GTM_OFF_BILR)
      next_cnt[1] = pwdata[15:0];
  end

  // Register read mux
  always @*
  begin
    hit = 1'b1;
    rdata = 32'h00000000;
    case (paddr)
      `GTM_OFF_CFG:  rdata = {29'h0, cfg};
      `GTM_OFF_AMR:  rdata = {28'h0, tmr[0]};
      `GTM_OFF_BMR:  rdata = {28'h0, tmr[1]};
      `GTM_OFF_CTL:  rdata = {16'h0, ctl};
      `GTM_OFF_IMR:  rdata = {16'h0, imr};
      `GTM_OFF_RIS:  rdata = {16'h0, ris};
      `GTM_OFF_MIS:  rdata = {16'h0, ris & imr};
      `GTM_OFF_ICR:  rdata = 32'h00000000;
      `GTM_OFF_AILR: rdata = cfg[2] ? {16'h0, ilr[0]} : {ilr[1], ilr[0]};
      `GTM_OFF_BILR: rdata = {16'h0, ilr[1]};
      `GTM_OFF_AMAT: rdata = cfg[2] ? {16'h0, mat[0]} : {mat[1], mat[0]};
      `GTM_OFF_BMAT: rdata = {16'h0, mat[1]};
      `GTM_OFF_APR:  rdata = {24'h0, pr[0]};
      `GTM_OFF_BPR:  rdata = {24'h0, pr[1]};
      `GTM_OFF_AVAL:
        if (!cfg[2])
          rdata = {cnt[1], cnt[0]};
        else
          rdata = {16'h0, (gtm_kind(cfg, tmr[0]) == K_TIM) ? cap[0] : cnt[0]};
      `GTM_OFF_BVAL: rdata = {16'h0, (gtm_kind(cfg, tmr[1]) == K_TIM) ? cap[1] : cnt[1]};
      default:       hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cfg <= 3'h0;
      tmr[0] <= 4'h0;
      tmr[1] <= 4'h0;
      ctl <= 16'h0000;
      imr <= 16'h0000;
      ris <= 16'h0000;
      ilr[0] <= `GTM_RST_CNT;
      ilr[1] <= `GTM_RST_CNT;
      mat[0] <= `GTM_RST_CNT;
      mat[1] <= `GTM_RST_CNT;
      pr[0] <= `GTM_RST_PR;
      pr[1] <= `GTM_RST_PR;
      cnt[0] <= `GTM_RST_CNT;
      cnt[1] <= `GTM_RST_CNT;
      psc[0] <= `GTM_RST_PR;
      psc[1] <= `GTM_RST_PR;
      cap[0] <= `GTM_RST_CNT;
      cap[1] <= `GTM_RST_CNT;
      lvl <= 2'b00;
      rdiv <= 15'h0000;
      pwm_a_out <= 1'b0;
      pwm_b_out <= 1'b0;
    end
    else
    begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready && !pwrite)
        prdata <= rdata;
      ctl <= next_ctl;
      ris <= next_ris;
      lvl <= next_lvl;
      rdiv <= next_rdiv;
      for (g = 0; g < 2; g = g + 1)
      begin
        cnt[g] <= next_cnt[g];
        psc[g] <= next_psc[g];
        cap[g] <= next_cap[g];
      end
      pwm_a_out <= next_lvl[0] ^ next_ctl[`GTM_CTL_PWML]; // see R14
      pwm_b_out <= next_lvl[1] ^ next_ctl[`GTM_HALF_SH+`GTM_CTL_PWML];
      if (wr)
      begin
        case (paddr)
          `GTM_OFF_CFG:  cfg <= pwdata[2:0];
          `GTM_OFF_AMR:  tmr[0] <= pwdata[3:0];
          `GTM_OFF_BMR:  tmr[1] <= pwdata[3:0];
          `GTM_OFF_IMR:  imr <= pwdata[15:0];
          `GTM_OFF_AILR:
          begin
            ilr[0] <= pwdata[15:0];
            if (!cfg[2])
              ilr[1] <= pwdata[31:16];
          end
          `GTM_OFF_BILR: ilr[1] <= pwdata[15:0];
          `GTM_OFF_AMAT:
          begin
            mat[0] <= pwdata[15:0];
            if (!cfg[2])
              mat[1] <= pwdata[31:16];
          end
          `GTM_OFF_BMAT: mat[1] <= pwdata[15:0];
          `GTM_OFF_APR:  pr[0] <= pwdata[7:0];
          `GTM_OFF_BPR:  pr[1] <= pwdata[7:0];
          default:       cfg <= cfg;
        endcase
      end
    end
  end
endmodule

// ===== gtm_timer_assertions.sv
`timescale 1ns/1ps
module gtm_timer_assertions
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire done    = psel && penable && pready;
  wire rd_done = done && !pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not after one wait cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (done && paddr == 12'h040 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_status_mapped: assert property (done && paddr == 12'h01c |-> !pslverr)
    else $error("status access refused");
  a_clear_reads0: assert property (rd_done && paddr == 12'h024 |-> prdata == 32'h0)
    else $error("clear register read not zero");
  a_cfg_reserved: assert property (rd_done && paddr == 12'h000 |-> prdata[31:3] == 29'h0)
    else $error("configuration reserved bits set");
  a_rdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data changed outside a transfer");
endmodule
bind gtm_timer gtm_timer_assertions chk_u
(
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr)
);

// ===== gtm_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module gtm_timer_tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         ccp_a;
  wire         ccp_b;
  wire         pwm_a;
  wire         pwm_b;
  logic [31:0] rd;
  logic [31:0] v1;
  logic        err;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          h;
  always #2.5 pclk = ~pclk;
  gtm_timer dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ccp_a_in(ccp_a), .ccp_b_in(ccp_b), .pwm_a_out(pwm_a), .pwm_b_out(pwm_b)
  );
  gtm_pin_model pin_a (.pclk(pclk), .pin(ccp_a));
  gtm_pin_model pin_b (.pclk(pclk), .pin(ccp_b));
  task complete_run;
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task xfer(input [11:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rc(input string n, input [11:0] a, input [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(n, e, rd)
  endtask
  task hi(input bit b, output int c);
    c = 0;
    repeat (100)
    begin
      @(negedge pclk);
      c += b ? pwm_b : pwm_a;
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial
  begin
    idle(12);
    presetn <= 1'b1;
    rc("cfg", 12'h000, 32'h0);
    rc("load", 12'h028, 32'hffffffff);
    rc("value", 12'h048, 32'hffffffff);
    rc("unmapped", 12'h040, 32'h0);
    `CHK("slverr", 1'b1, err)
    // Edge count, both edges, load 10 match 6
    wr(12'h000, 32'h4);
    wr(12'h004, 32'h3);
    wr(12'h00c, 32'h8);
    wr(12'h028, 32'ha);
    wr(12'h030, 32'h6);
    wr(12'h018, 32'h2);
    wr(12'h00c, 32'h9);
    pin_a.flip(3);
    idle(8);
    rc("cnt_mid", 12'h048, 32'h7);
    rc("cnt_none", 12'h01c, 32'h0);
    pin_a.flip(3);
    idle(8);
    rc("cnt_ris", 12'h01c, 32'h2);
    rc("cnt_mis", 12'h020, 32'h2);
    rc("cnt_ctl", 12'h00c, 32'h8);
    rc("cnt_val", 12'h048, 32'ha);
    wr(12'h024, 32'h2);
    rc("cnt_clr", 12'h01c, 32'h0);
    // Edge time, rising edges only
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h7);
    wr(12'h028, 32'hffff);
    wr(12'h00c, 32'h1);
    pin_a.flip(1);
    idle(8);
    rc("cap_ris", 12'h01c, 32'h4);
    v1 = rd;
    xfer(12'h048, 1'b0, 32'h0);
    v1 = rd;
    pin_a.flip(1);
    idle(8);
    rc("cap_hold", 12'h048, v1);
    pin_a.flip(1);
    idle(8);
    xfer(12'h048, 1'b0, 32'h0);
    `CHK("cap_new", 1'b1, rd < v1)
    // Half B edge count, falling edges only, load 5 match 3
    wr(12'h008, 32'h3);
    wr(12'h02c, 32'h5);
    wr(12'h034, 32'h3);
    wr(12'h00c, 32'h401);
    wr(12'h00c, 32'h501);
    pin_b.flip(2);
    rc("bcnt_mid", 12'h04c, 32'h4);
    pin_b.flip(2);
    rc("bcnt_ris", 12'h01c, 32'h204);
    rc("bcnt_ctl", 12'h00c, 32'h401);
    rc("bcnt_val", 12'h04c, 32'h5);
    wr(12'h024, 32'h200);
    // PWM, period 10, match 3, prescale ignored
    wr(12'h00c, 32'h0);
    wr(12'h024, 32'hff);
    wr(12'h038, 32'h5);
    wr(12'h004, 32'ha);
    wr(12'h028, 32'h9);
    wr(12'h030, 32'h3);
    wr(12'h00c, 32'h1);
    idle(20);
    hi(1'b0, h);
    `CHK("pwm_hi", 60, h)
    rc("pwm_ris", 12'h01c, 32'h0);
    wr(12'h00c, 32'h0);
    wr(12'h00c, 32'h41);
    idle(20);
    hi(1'b0, h);
    `CHK("pwm_inv", 40, h)
    // Half B PWM beside the inverted half A
    wr(12'h008, 32'ha);
    wr(12'h02c, 32'h9);
    wr(12'h034, 32'h3);
    wr(12'h00c, 32'h141);
    idle(20);
    hi(1'b1, h);
    `CHK("pwm_b", 60, h)
    // Half B 16-bit periodic then one-shot, prescale 1
    wr(12'h00c, 32'h0);
    wr(12'h008, 32'h2);
    wr(12'h03c, 32'h1);
    wr(12'h02c, 32'h4);
    wr(12'h024, 32'hffff);
    wr(12'h00c, 32'h100);
    idle(40);
    rc("per16_ris", 12'h01c, 32'h100);
    rc("per16_ctl", 12'h00c, 32'h100);
    wr(12'h00c, 32'h0);
    wr(12'h008, 32'h1);
    wr(12'h024, 32'h100);
    rc("one16_clr", 12'h01c, 32'h0);
    wr(12'h00c, 32'h100);
    idle(40);
    rc("one16_ctl", 12'h00c, 32'h0);
    rc("one16_ris", 12'h01c, 32'h100);
    wr(12'h024, 32'h100);
    // 32-bit periodic then one-shot
    wr(12'h00c, 32'h0);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h2);
    wr(12'h028, 32'h20);
    wr(12'h00c, 32'h1);
    idle(80);
    rc("per_ris", 12'h01c, 32'h1);
    rc("per_ctl", 12'h00c, 32'h1);
    wr(12'h00c, 32'h0);
    wr(12'h024, 32'h1);
    rc("per_clr", 12'h01c, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h028, 32'h00010004);
    wr(12'h00c, 32'h1);
    idle(20);
    xfer(12'h048, 1'b0, 32'h0);
    `CHK("join", 24'h0000ff, rd[31:8])
    idle(65600);
    rc("one_ctl", 12'h00c, 32'h0);
    rc("one_ris", 12'h01c, 32'h1);
    // Clock mode set-up; no ticks arrive, so the count stays at its first value
    wr(12'h024, 32'h1);
    wr(12'h000, 32'h1);
    rc("rtc_load", 12'h048, 32'h1);
    wr(12'h030, 32'h5);
    wr(12'h00c, 32'h11);
    idle(20);
    rc("rtc_hold", 12'h048, 32'h1);
    rc("rtc_ris", 12'h01c, 32'h0);
    complete_run;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail_count++;
      complete_run;
    end
  end
endmodule
